/* atpc_pkg.sv */
package atpc_pkg;
    localparam int SAMPLE_W   = 12;
    localparam int REG_W      = 8;
    localparam int FIFO_DEPTH = 8;

    localparam logic [7:0] OFS_OUTPUT_FORMAT = 8'h14;
    localparam logic [7:0] OFS_REFERENCE     = 8'h18;
    localparam logic [7:0] OFS_USER1_LOW     = 8'h19;
    localparam logic [7:0] OFS_USER1_HIGH    = 8'h1A;
    localparam logic [7:0] OFS_USER2_LOW     = 8'h1B;
    localparam logic [7:0] OFS_USER2_HIGH    = 8'h1C;
    localparam logic [7:0] OFS_FILTER        = 8'h2B;
    localparam logic [7:0] OFS_IMPEDANCE     = 8'h2C;
    localparam logic [7:0] OFS_TEST_MODE     = 8'h30;

    localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;
    localparam logic [7:0] RST_REFERENCE     = 8'h03;
    localparam logic [7:0] RST_USER          = 8'h00;
    localparam logic [7:0] RST_FILTER        = 8'h00;
    localparam logic [7:0] RST_IMPEDANCE     = 8'h00;
    localparam logic [7:0] RST_TEST_MODE     = 8'h00;

    localparam int REF_SRC_BIT   = 6;
    localparam int REF_LEVEL_LSB = 0;
    localparam int TUNE_BIT      = 6;
    localparam int IMP_BIT       = 0;
    localparam int FMT_LSB       = 0;
    localparam logic [1:0] FMT_TWOS = 2'h1;

    localparam logic [3:0] TM_OFF      = 4'h0;
    localparam logic [3:0] TM_MID      = 4'h1;
    localparam logic [3:0] TM_POS_FS   = 4'h2;
    localparam logic [3:0] TM_NEG_FS   = 4'h3;
    localparam logic [3:0] TM_CHECKER  = 4'h4;
    localparam logic [3:0] TM_PN_LONG  = 4'h5;
    localparam logic [3:0] TM_PN_SHORT = 4'h6;
    localparam logic [3:0] TM_ONE_ZERO = 4'h7;
    localparam logic [3:0] TM_USER     = 4'h8;
    localparam logic [3:0] TM_BIT_TOG  = 4'h9;
    localparam logic [3:0] TM_SYNC     = 4'hA;
    localparam logic [3:0] TM_ONE_HIGH = 4'hB;
    localparam logic [3:0] TM_MIXED    = 4'hC;

    localparam logic [11:0] W_MID     = 12'h800;
    localparam logic [11:0] W_ONES    = 12'hFFF;
    localparam logic [11:0] W_ZEROS   = 12'h000;
    localparam logic [11:0] W_CHECK_A = 12'hAAA;
    localparam logic [11:0] W_CHECK_B = 12'h555;
    localparam logic [11:0] W_SYNC    = 12'h03F;
    localparam logic [11:0] W_MIXED   = 12'hA33;

    localparam logic [22:0] PN_LONG_SEED  = 23'h7FFFFF;
    localparam logic [8:0]  PN_SHORT_SEED = 9'h1FF;

    typedef struct packed {
        logic        is_pattern;
        logic [11:0] word;
    } atpc_sample_s;
endpackage

/* atpc_top.sv */
// Functional notes
// RULE_01: Reference bit 6 picks internal/external; reset 0x03.
// RULE_02: Filter bit 6 starts tuning, self-clears.
// RULE_03: Modes 1-3 repeat fixed word, format applied.
// RULE_04: Modes 4, 7 alternate words, no format.
// RULE_05: Mode 8 alternates user patterns, no format.
// RULE_06: User patterns are 16-bit, low byte first.
// RULE_07: Off passes data; PN formatted; 9-12 fixed.
// RULE_08: Output format selects offset binary or twos.
// RULE_09: Codes 13 to 15 behave as off.
`timescale 1ns/100ps
`default_nettype none

module atpc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_in,    // Sample clock.
    input  wire logic             sys_rst_in,  // Synchronous reset.
    input  wire logic             in_valid_in, // Write request.
    output logic                  in_ready_out,// Not full.
    input  wire logic [WIDTH-1:0] in_data_in,  // Write data.
    output logic                  out_valid_out,// Not empty.
    input  wire logic             out_ready_in,// Read accept.
    output logic [WIDTH-1:0]      out_data_out // Head word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem_r[rd_ptr_r];

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

module atpc_top (
    input  wire logic        clock_in,          // 40 MHz sample clock.
    input  wire logic        sys_rst_in,        // Synchronous reset, active high.
    input  wire logic        reg_wr_in,         // Register write strobe.
    input  wire logic        reg_rd_in,         // Register read strobe.
    input  wire logic [7:0]  reg_addr_in,       // Register offset.
    input  wire logic [7:0]  reg_wdata_in,      // Write data.
    output logic      [7:0]  reg_rdata_out,     // Read data, valid after read.
    input  wire logic        tune_done_in,      // Filter tuning finished, async.
    output logic             tune_start_out,    // Filter tuning request level.
    output logic             ref_external_out,  // External reference selected.
    output logic      [1:0]  ref_level_out,     // Internal reference level code.
    output logic             imp_high_out,      // High input impedance selected.
    input  wire logic [11:0] adc_data_in,       // Converted sample.
    input  wire logic        adc_valid_in,      // Sample strobe.
    output logic             adc_ready_out,     // Output buffer can take a sample.
    output logic      [11:0] out_data_out,      // Output word.
    output logic             out_pattern_out,   // Word is a test pattern.
    output logic             out_valid_out,     // Output word valid.
    input  wire logic        out_ready_in       // Capture logic accepts word.
);
    logic [7:0]  out_format_r;
    logic [7:0]  reference_r;
    logic [7:0]  user1_low_r;
    logic [7:0]  user1_high_r;
    logic [7:0]  user2_low_r;
    logic [7:0]  user2_high_r;
    logic [7:0]  filter_r;
    logic [7:0]  impedance_r;
    logic [3:0]  test_mode_r;
    logic        phase_r;
    logic [22:0] pn_long_r;
    logic [8:0]  pn_short_r;
    logic        done_s1_r;
    logic        done_s2_r;
    logic        push;
    logic        twos;
    logic [11:0] raw_word;
    logic        fmt_dep;
    atpc_pkg::atpc_sample_s sample_nxt;
    atpc_pkg::atpc_sample_s head;
    logic [15:0] user1;
    logic [15:0] user2;

    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        wr_hit = wr && (a == ofs);
    endfunction

    assign user1 = {user1_high_r, user1_low_r}; // RULE_06
    assign user2 = {user2_high_r, user2_low_r}; // RULE_06
    assign twos  = (out_format_r[atpc_pkg::FMT_LSB +: 2] == atpc_pkg::FMT_TWOS); // RULE_08

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            out_format_r <= atpc_pkg::RST_OUTPUT_FORMAT;
            reference_r  <= atpc_pkg::RST_REFERENCE; // RULE_01
            impedance_r  <= atpc_pkg::RST_IMPEDANCE;
            test_mode_r  <= atpc_pkg::RST_TEST_MODE[3:0];
        end else begin
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_OUTPUT_FORMAT)) begin
                out_format_r <= reg_wdata_in;
            end
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_REFERENCE)) begin
                reference_r <= reg_wdata_in; // RULE_01
            end
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_IMPEDANCE)) begin
                impedance_r <= reg_wdata_in;
            end
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_TEST_MODE)) begin
                test_mode_r <= reg_wdata_in[3:0];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            user1_low_r  <= atpc_pkg::RST_USER; // RULE_06
            user1_high_r <= atpc_pkg::RST_USER;
            user2_low_r  <= atpc_pkg::RST_USER;
            user2_high_r <= atpc_pkg::RST_USER;
        end else begin
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_USER1_LOW)) begin
                user1_low_r <= reg_wdata_in; // RULE_06
            end
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_USER1_HIGH)) begin
                user1_high_r <= reg_wdata_in;
            end
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_USER2_LOW)) begin
                user2_low_r <= reg_wdata_in;
            end
            if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_USER2_HIGH)) begin
                user2_high_r <= reg_wdata_in;
            end
        end
    end

    // The done line comes from the analog tuner, so it is synchronised first.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
        end else begin
            done_s1_r <= tune_done_in;
            done_s2_r <= done_s1_r;
        end
    end

    // A software start in the same cycle as a completion wins over the clear.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            filter_r <= atpc_pkg::RST_FILTER; // RULE_02
        end else if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_FILTER)) begin
            filter_r <= reg_wdata_in; // RULE_02
        end else if (done_s2_r) begin
            filter_r[atpc_pkg::TUNE_BIT] <= 1'b0; // RULE_02
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                atpc_pkg::OFS_OUTPUT_FORMAT: reg_rdata_out <= out_format_r;
                atpc_pkg::OFS_REFERENCE:     reg_rdata_out <= reference_r;
                atpc_pkg::OFS_USER1_LOW:     reg_rdata_out <= user1_low_r;
                atpc_pkg::OFS_USER1_HIGH:    reg_rdata_out <= user1_high_r;
                atpc_pkg::OFS_USER2_LOW:     reg_rdata_out <= user2_low_r;
                atpc_pkg::OFS_USER2_HIGH:    reg_rdata_out <= user2_high_r;
                atpc_pkg::OFS_FILTER:        reg_rdata_out <= filter_r;
                atpc_pkg::OFS_IMPEDANCE:     reg_rdata_out <= impedance_r;
                atpc_pkg::OFS_TEST_MODE:     reg_rdata_out <= {4'h0, test_mode_r};
                default:                     reg_rdata_out <= 8'h00;
            endcase
        end
    end

    assign tune_start_out   = filter_r[atpc_pkg::TUNE_BIT]; // RULE_02
    assign ref_external_out = reference_r[atpc_pkg::REF_SRC_BIT]; // RULE_01
    assign ref_level_out    = reference_r[atpc_pkg::REF_LEVEL_LSB +: 2];
    assign imp_high_out     = impedance_r[atpc_pkg::IMP_BIT];

    always_comb begin
        raw_word = adc_data_in;
        fmt_dep  = 1'b1;
        unique case (test_mode_r)
            atpc_pkg::TM_OFF:      raw_word = adc_data_in; // RULE_07
            atpc_pkg::TM_MID:      raw_word = atpc_pkg::W_MID; // RULE_03
            atpc_pkg::TM_POS_FS:   raw_word = atpc_pkg::W_ONES; // RULE_03
            atpc_pkg::TM_NEG_FS:   raw_word = atpc_pkg::W_ZEROS; // RULE_03
            atpc_pkg::TM_PN_LONG:  raw_word = pn_long_r[11:0]; // RULE_07
            atpc_pkg::TM_PN_SHORT: raw_word = {pn_short_r, pn_short_r[8:6]}; // RULE_07
            atpc_pkg::TM_CHECKER: begin
                raw_word = phase_r ? atpc_pkg::W_CHECK_B : atpc_pkg::W_CHECK_A; // RULE_04
                fmt_dep  = 1'b0;
            end
            atpc_pkg::TM_ONE_ZERO: begin
                raw_word = phase_r ? atpc_pkg::W_ZEROS : atpc_pkg::W_ONES; // RULE_04
                fmt_dep  = 1'b0;
            end
            atpc_pkg::TM_USER: begin
                raw_word = phase_r ? user2[11:0] : user1[11:0]; // RULE_05
                fmt_dep  = 1'b0;
            end
            atpc_pkg::TM_BIT_TOG: begin
                raw_word = atpc_pkg::W_CHECK_A; // RULE_07
                fmt_dep  = 1'b0;
            end
            atpc_pkg::TM_SYNC: begin
                raw_word = atpc_pkg::W_SYNC; // RULE_07
                fmt_dep  = 1'b0;
            end
            atpc_pkg::TM_ONE_HIGH: begin
                raw_word = atpc_pkg::W_MID; // RULE_07
                fmt_dep  = 1'b0;
            end
            atpc_pkg::TM_MIXED: begin
                raw_word = atpc_pkg::W_MIXED; // RULE_07
                fmt_dep  = 1'b0;
            end
            default:               raw_word = adc_data_in; // RULE_09
        endcase
        sample_nxt.word       = raw_word ^ {fmt_dep & twos, 11'h000}; // RULE_08
        sample_nxt.is_pattern = (test_mode_r != atpc_pkg::TM_OFF) && (test_mode_r <= atpc_pkg::TM_MIXED);
    end

    assign push = adc_valid_in && adc_ready_out;

    // Phase restarts on a mode write so each alternating pattern (modes 4, 7, 8) begins with its first word.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            phase_r <= 1'b0;
        end else if (wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_TEST_MODE)) begin
            phase_r <= 1'b0;
        end else if (push) begin
            phase_r <= ~phase_r; // RULE_04
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pn_long_r  <= atpc_pkg::PN_LONG_SEED;
            pn_short_r <= atpc_pkg::PN_SHORT_SEED;
        end else if (push) begin
            if (test_mode_r == atpc_pkg::TM_PN_LONG) begin
                pn_long_r <= {pn_long_r[21:0], pn_long_r[22] ^ pn_long_r[17]}; // RULE_07
            end
            if (test_mode_r == atpc_pkg::TM_PN_SHORT) begin
                pn_short_r <= {pn_short_r[7:0], pn_short_r[8] ^ pn_short_r[4]}; // RULE_07
            end
        end
    end

    atpc_fifo #(
        .WIDTH ($bits(atpc_pkg::atpc_sample_s)),
        .DEPTH (atpc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_in      (clock_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (adc_valid_in),
        .in_ready_out  (adc_ready_out),
        .in_data_in    (sample_nxt),
        .out_valid_out (out_valid_out),
        .out_ready_in  (out_ready_in),
        .out_data_out  (head)
    );

    assign out_data_out    = head.word;
    assign out_pattern_out = head.is_pattern;

    AST_REF_SRC: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_01
        wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_REFERENCE)
        |=> ref_external_out == $past(reg_wdata_in[6]))
        else $error("Reference source does not follow the written bit.");

    AST_TUNE_CLEAR: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_02
        tune_start_out && done_s2_r && !reg_wr_in |=> !tune_start_out)
        else $error("Tuning bit did not clear after completion.");

    AST_MID_WORD: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_03
        push && test_mode_r == atpc_pkg::TM_MID |-> sample_nxt.word == (twos ? 12'h000 : 12'h800))
        else $error("Midscale word wrong for the selected format.");

    AST_CHECKER: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_04
        push && test_mode_r == atpc_pkg::TM_CHECKER
        |-> sample_nxt.word == (phase_r ? 12'h555 : 12'hAAA))
        else $error("Checkerboard did not alternate.");

    AST_USER_ALT: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_05
        push && test_mode_r == atpc_pkg::TM_USER && !phase_r |-> sample_nxt.word == user1[11:0])
        else $error("User pattern 1 not sent on the first phase.");

    AST_USER_RB: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_06
        wr_hit(reg_wr_in, reg_addr_in, atpc_pkg::OFS_USER2_HIGH)
        |=> user2[15:8] == $past(reg_wdata_in))
        else $error("User pattern 2 high byte not stored.");

    AST_BYPASS: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_07
        push && test_mode_r == atpc_pkg::TM_SYNC |-> sample_nxt.word == 12'h03F)
        else $error("Sync word altered.");

    AST_TWOS_DATA: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_08
        push && test_mode_r == atpc_pkg::TM_OFF
        |-> sample_nxt.word == (adc_data_in ^ {twos, 11'h000}))
        else $error("Format conversion wrong on live data.");

    AST_UNLISTED: assert property (@(posedge clock_in) disable iff (sys_rst_in) // RULE_09
        push && test_mode_r > atpc_pkg::TM_MIXED |-> !sample_nxt.is_pattern)
        else $error("Unlisted test code produced a pattern.");
endmodule

`default_nettype wire

/* atpc_sink.sv */
`timescale 1ns/100ps
`default_nettype none
module atpc_sink (
    input  wire logic                   clock_in,   // Sample clock.
    input  wire logic                   sys_rst_in, // Synchronous reset.
    input  wire logic                   stall_in,   // Hold off acceptance.
    input  wire logic                   valid_in,   // Word offered.
    input  wire atpc_pkg::atpc_sample_s word_in,    // Offered word.
    output logic                        ready_out   // Word accepted.
);
    atpc_pkg::atpc_sample_s got[$];
    // Ready is registered, so a stall bites one cycle late, as in a real capture stage.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= !stall_in;
        end
    end
    always @(posedge clock_in) begin
        if (!sys_rst_in && valid_in && ready_out) begin
            got.push_back(word_in);
        end
    end
endmodule
`default_nettype wire

/* atpc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module atpc_top_tb;
    logic                   clock_in = 1'b0;
    logic                   sys_rst_in = 1'b1;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [7:0]             reg_addr = 8'h00;
    logic [7:0]             reg_wdata = 8'h00;
    logic [7:0]             reg_rdata;
    logic                   tune_done = 1'b0;
    logic                   tune_start;
    logic                   ref_ext;
    logic [1:0]             ref_lvl;
    logic                   imp_high;
    logic [11:0]            adc_data = 12'h000;
    logic                   adc_valid = 1'b0;
    logic                   adc_ready;
    logic [11:0]            out_data;
    logic                   out_pattern;
    logic                   out_valid;
    logic                   out_ready;
    logic                   stall = 1'b0;
    atpc_pkg::atpc_sample_s head_w;
    int                     miscompares = 0;
    int                     checks_done = 0;
    int                     cycles = 0;

    assign head_w = {out_pattern, out_data};
    always #12.5 clock_in = ~clock_in;

    atpc_top i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .tune_done_in(tune_done), .tune_start_out(tune_start),
        .ref_external_out(ref_ext), .ref_level_out(ref_lvl), .imp_high_out(imp_high),
        .adc_data_in(adc_data), .adc_valid_in(adc_valid), .adc_ready_out(adc_ready),
        .out_data_out(out_data), .out_pattern_out(out_pattern), .out_valid_out(out_valid),
        .out_ready_in(out_ready));
    atpc_sink i_sink (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .stall_in(stall),
        .valid_in(out_valid), .word_in(head_w), .ready_out(out_ready));

    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // The whole sequence needs well under this many cycles.
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock_in);
        reg_rd <= 1'b0;
        @(negedge clock_in);
        check("register read", reg_rdata, exp);
    endtask
    // A push first checks that the buffer reports room, so a lost sample is counted as a miscompare.
    task automatic push(input logic [11:0] d);
        @(negedge clock_in);
        check("input ready", adc_ready, 1'b1);
        @(posedge clock_in);
        adc_valid <= 1'b1;
        adc_data <= d;
        @(posedge clock_in);
        adc_valid <= 1'b0;
    endtask
    task automatic take(output atpc_pkg::atpc_sample_s w);
        for (int i = 0; i < 50 && i_sink.got.size() == 0; i++) @(negedge clock_in);
        check("word arrived", i_sink.got.size() != 0, 1'b1);
        w = (i_sink.got.size() != 0) ? i_sink.got.pop_front() : '0;
    endtask

    task automatic test_regs();
        rd_check(atpc_pkg::OFS_REFERENCE, 8'h03);
        check("ref level", ref_lvl, 2'h3);
        for (int a = 8'h19; a <= 8'h1C; a++) rd_check(8'(a), 8'h00);
        rd_check(atpc_pkg::OFS_FILTER, 8'h00);
        rd_check(atpc_pkg::OFS_IMPEDANCE, 8'h00);
        rd_check(atpc_pkg::OFS_OUTPUT_FORMAT, 8'h00);
        wr(atpc_pkg::OFS_REFERENCE, 8'h40);
        @(negedge clock_in);
        check("external ref", {ref_ext, ref_lvl}, 3'h4);
        rd_check(atpc_pkg::OFS_REFERENCE, 8'h40);
        wr(atpc_pkg::OFS_REFERENCE, 8'h02);
        @(negedge clock_in);
        check("internal ref", {ref_ext, ref_lvl}, 3'h2);
        wr(atpc_pkg::OFS_IMPEDANCE, 8'h01);
        @(negedge clock_in);
        check("impedance", imp_high, 1'b1);
        wr(8'h7F, 8'hA5);
        rd_check(8'h7F, 8'h00);
    endtask

    task automatic test_tuning();
        int i;
        wr(atpc_pkg::OFS_FILTER, 8'h40);
        @(negedge clock_in);
        check("tune start", tune_start, 1'b1);
        @(posedge clock_in);
        tune_done <= 1'b1;
        // Done is first sampled one edge after it is raised, so the bit is seen low
        // at the fourth falling edge: two synchroniser edges and the clearing edge.
        for (i = 0; i < 6 && tune_start === 1'b1; i++) @(negedge clock_in);
        check("tune clear delay", 16'(i), 16'h0004);
        rd_check(atpc_pkg::OFS_FILTER, 8'h00);
        @(posedge clock_in);
        tune_done <= 1'b0;
    endtask

    task automatic test_fixed();
        atpc_pkg::atpc_sample_s w;
        logic [11:0]            e;
        logic [11:0]            fl;
        for (int f = 0; f < 2; f++) begin
            wr(atpc_pkg::OFS_OUTPUT_FORMAT, f ? 8'h01 : 8'h00);
            fl = f ? 12'h800 : 12'h000;
            for (int m = 0; m < 16; m++) begin
                if (m == 4 || m == 7 || m == 8) continue;
                wr(atpc_pkg::OFS_TEST_MODE, 8'(m));
                push(12'h123);
                take(w);
                case (m)
                    1: e = 12'h800 ^ fl;
                    2: e = 12'hFFF ^ fl;
                    3: e = 12'h000 ^ fl;
                    9: e = 12'hAAA;
                    10: e = 12'h03F;
                    11: e = 12'h800;
                    12: e = 12'hA33;
                    // Each generator shifts once per pattern sample, starting from all ones.
                    5: e = f ? 12'h7FE : 12'hFFF;
                    6: e = f ? 12'h7F7 : 12'hFFF;
                    default: e = 12'h123 ^ fl;
                endcase
                check("pattern flag", w.is_pattern, m >= 1 && m <= 12);
                check("fixed word", w.word, e);
            end
        end
    endtask

    task automatic test_alternate();
        atpc_pkg::atpc_sample_s w;
        logic [3:0]             modes[3] = '{4'h4, 4'h7, 4'h8};
        logic [11:0]            wa[3] = '{12'hAAA, 12'hFFF, 12'h234};
        logic [11:0]            wb[3] = '{12'h555, 12'h000, 12'hACD};
        wr(atpc_pkg::OFS_OUTPUT_FORMAT, 8'h01);
        wr(atpc_pkg::OFS_USER1_LOW, 8'h34);
        wr(atpc_pkg::OFS_USER1_HIGH, 8'hF2);
        wr(atpc_pkg::OFS_USER2_LOW, 8'hCD);
        wr(atpc_pkg::OFS_USER2_HIGH, 8'h5A);
        rd_check(atpc_pkg::OFS_USER1_HIGH, 8'hF2);
        rd_check(atpc_pkg::OFS_USER2_LOW, 8'hCD);
        for (int k = 0; k < 3; k++) begin
            wr(atpc_pkg::OFS_TEST_MODE, {4'h0, modes[k]});
            for (int i = 0; i < 4; i++) push(12'h321);
            for (int i = 0; i < 4; i++) begin
                take(w);
                check("alternating word", w.word, i[0] ? wb[k] : wa[k]);
            end
        end
    endtask

    task automatic test_fill();
        atpc_pkg::atpc_sample_s w;
        wr(atpc_pkg::OFS_OUTPUT_FORMAT, 8'h00);
        wr(atpc_pkg::OFS_TEST_MODE, 8'h00);
        @(posedge clock_in);
        stall <= 1'b1;
        repeat (2) @(posedge clock_in);
        for (int i = 0; i < 8; i++) push(12'(12'h100 + i));
        @(negedge clock_in);
        check("full refuses", adc_ready, 1'b0);
        check("nothing passed stall", 16'(i_sink.got.size()), 16'h0000);
        stall <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            take(w);
            check("live data order", w.word, 12'(12'h100 + i));
        end
        repeat (4) @(negedge clock_in);
        check("drained", out_valid, 1'b0);
    endtask

    initial begin
        repeat (8) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        test_regs();
        test_tuning();
        test_fixed();
        test_alternate();
        test_fill();
        print_verdict();
    end
endmodule
`default_nettype wire
